// File: src/pcc_pkg.sv
// Constants and types for the panel clock.
// Assumes a 100 MHz clock and synchronous, debounced button inputs.
package pcc_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned TICK_CYCLES     = CLK_HZ;
  localparam int unsigned IDLE_S          = 10;
  localparam int unsigned IDLE_CYCLES     = IDLE_S * CLK_HZ;
  localparam int unsigned PFAIL_MS        = 30;
  localparam int unsigned PFAIL_CYCLES    = PFAIL_MS * (CLK_HZ / 1000);
  localparam int unsigned SAVE_CYCLES     = 16;
  localparam logic [16:0] DAY_SECONDS     = 17'h15180;
  localparam logic [16:0] NOON_SECONDS    = 17'h0a8c0;
  localparam logic [16:0] HOUR_SECONDS    = 17'h00e10;
  localparam logic [16:0] MINUTE_SECONDS  = 17'h0003c;
  localparam logic [15:0] DEF_CODE        = 16'h0000;
  localparam logic [16:0] DEF_SYNC_TIME   = 17'h0a8c0;
  localparam logic [1:0]  DEF_FORMAT      = 2'h0;
  localparam logic [1:0]  DEF_OUT_ENABLE  = 2'h0;
  localparam logic        DEF_FUNCTION    = 1'b1;
  localparam logic [15:0] CONFIRM_WORD    = 16'h5c0e;
  localparam logic [3:0]  CHAR_MAX        = 4'hf;

  typedef enum logic [1:0] {
    FMT_12_SEC, FMT_12_NOSEC, FMT_24_SEC, FMT_24_NOSEC
  } pcc_format_t;

  typedef enum logic [3:0] {
    MI_FUNCTION, MI_FORMAT, MI_SET_TIME, MI_SYNC_TIME, MI_OUT1_EN, MI_OUT1_T,
    MI_OUT2_EN, MI_OUT2_T, MI_ALARM_EN, MI_ALARM_CODE, MI_CODE, MI_DEFAULTS
  } pcc_item_t;
endpackage

// File: src/pcc_timekeeper.sv
// Seconds-of-day counter with load, hold and unset state.
// Assumes one-cycle tick pulses from the owner.
`timescale 1ns/10ps
module pcc_timekeeper
  import pcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        tick,
  input  wire logic        hold,
  input  wire logic        load,
  input  wire logic [16:0] load_value,
  input  wire logic        clear,
  output logic [16:0]      now,
  output logic             is_set
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      now <= 17'h00000;
    end else if (clear) begin
      now <= 17'h00000;
    end else if (load) begin
      now <= load_value;
    end else if (tick && !hold && is_set) begin
      now <= (now == DAY_SECONDS - 17'h1) ? 17'h00000 : now + 17'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      is_set <= 1'b0;
    end else if (clear) begin
      is_set <= 1'b0;
    end else if (load) begin
      is_set <= 1'b1;
    end
  end
endmodule

// File: src/pcc_outctl.sv
// One control output: up to two on/off pairs per day.
// Assumes times in seconds of day.
`timescale 1ns/10ps
module pcc_outctl
  import pcc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [1:0]  enable,
  input  wire logic [16:0] now,
  input  wire logic        running,
  input  wire logic [16:0] on_time [2],
  input  wire logic [16:0] off_time [2],
  output logic             state
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= 1'b0;
    end else if (enable == 2'h0 || !running) begin
      state <= 1'b0;
    end else if (now == on_time[0] || (enable == 2'h2 && now == on_time[1])) begin
      state <= 1'b1;
    end else if (now == off_time[0] || (enable == 2'h2 && now == off_time[1])) begin
      state <= 1'b0;
    end
  end
endmodule

// File: src/pcc_top.sv
// Panel clock: timekeeping, menu, code gate and outputs.
// Assumes one-cycle debounced button pulses and a power-fail level input.
`timescale 1ns/10ps
module pcc_top
  import pcc_pkg::*;
#(
  parameter int unsigned TICK_LEN  = TICK_CYCLES,
  parameter int unsigned IDLE_LEN  = IDLE_CYCLES,
  parameter int unsigned PFAIL_LEN = PFAIL_CYCLES
)(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        SYNC_CONTACT_A,
  input  wire logic        SYNC_CONTACT_B,
  input  wire logic        POWER_LOW,
  input  wire logic        BTN_P,
  input  wire logic        BTN_E,
  input  wire logic        BTN_UP,
  input  wire logic        BTN_DOWN,
  output logic [16:0]      DISPLAY_TIME,
  output logic [1:0]       DISPLAY_FORMAT,
  output logic             DISPLAY_SECONDS,
  output logic             DISPLAY_FLASH,
  output logic             MARK_AM,
  output logic             MARK_PM,
  output logic             ANN_RESET,
  output logic             ANN_OUT1,
  output logic             ANN_OUT2,
  output logic             CONTROL_OUTPUT_ONE,
  output logic             CONTROL_OUTPUT_TWO,
  output logic             IN_MENU,
  output logic             CODE_PROMPT,
  output logic [3:0]       MENU_ITEM,
  output logic             SAVING,
  output logic             SAVE_REQ,
  output logic             INSTRUMENT_FUNCTION
);
  typedef enum logic [2:0] {
    ST_DISPLAY, ST_CODE, ST_MENU, ST_EDIT_TIME, ST_EDIT_WORD, ST_EDIT_SEL, ST_SAVE
  } pcc_state_t;

  pcc_state_t  state;
  pcc_item_t   item;
  logic [15:0] menu_code;
  logic [15:0] alarm_access_code;
  logic        alarm_access_function;
  logic        instrument_function_setting;
  logic [1:0]  display_format_setting;
  logic [16:0] sync_time_setting;
  logic [1:0]  out_enable [2];
  logic [16:0] on_time  [2][2];
  logic [16:0] off_time [2][2];
  logic [15:0] word;
  logic [1:0]  digit;
  logic [16:0] edit_time;
  logic [1:0]  edit_sel;
  logic [1:0]  edit_field;
  logic        pair_sel;
  logic        dirty;
  logic        set_load;
  logic [31:0] tick_count;
  logic [31:0] idle_count;
  logic [31:0] pfail_count;
  logic [4:0]  save_count;
  logic        tick;
  logic        idle_expired;
  logic        sync_closed;
  logic        pfail_clear;
  logic        any_button;
  logic [16:0] now;
  logic        is_set;
  logic        out_state [2];
  logic [16:0] time_step;
  logic [3:0]  cur_char;
  logic [15:0] next_word;

  assign sync_closed  = SYNC_CONTACT_A && SYNC_CONTACT_B;
  assign any_button   = BTN_P || BTN_E || BTN_UP || BTN_DOWN;
  assign tick         = (tick_count == TICK_LEN - 1);
  assign idle_expired = (idle_count == IDLE_LEN - 1);
  assign pfail_clear  = (pfail_count == PFAIL_LEN - 1);
  assign time_step    = (edit_field == 2'h0) ? HOUR_SECONDS :
                        (edit_field == 2'h1) ? MINUTE_SECONDS : 17'h00001;
  assign cur_char     = word[4'(digit) * 4 +: 4];

  always_comb begin
    next_word = word;
    if (BTN_UP) begin
      next_word[4'(digit) * 4 +: 4] = cur_char + 4'h1;
    end else if (BTN_DOWN) begin
      next_word[4'(digit) * 4 +: 4] = cur_char - 4'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tick_count <= 32'h0;
    end else begin
      tick_count <= tick ? 32'h0 : tick_count + 32'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pfail_count <= 32'h0;
    end else if (!POWER_LOW) begin
      pfail_count <= 32'h0;
    end else if (!pfail_clear) begin
      pfail_count <= pfail_count + 32'h1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      idle_count <= 32'h0;
    end else if (any_button || state == ST_DISPLAY || state == ST_SAVE) begin
      idle_count <= 32'h0;
    end else if (!idle_expired) begin
      idle_count <= idle_count + 32'h1;
    end
  end

  pcc_timekeeper u_time (
    .clk        (CLK),
    .rst_n      (RST_N),
    .tick       (tick),
    .hold       (sync_closed),
    .load       (sync_closed || set_load),
    .load_value (set_load ? edit_time : sync_time_setting),
    .clear      (pfail_clear),
    .now        (now),
    .is_set     (is_set)
  );

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_out
      pcc_outctl u_out (
        .clk      (CLK),
        .rst_n    (RST_N),
        .enable   (out_enable[g]),
        .now      (now),
        .running  (is_set),
        .on_time  (on_time[g]),
        .off_time (off_time[g]),
        .state    (out_state[g])
      );
    end
  endgenerate

  // Menu state machine and settings store
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state                       <= ST_DISPLAY;
      item                        <= MI_FUNCTION;
      menu_code                   <= DEF_CODE;
      alarm_access_code           <= DEF_CODE;
      alarm_access_function       <= 1'b0;
      instrument_function_setting <= DEF_FUNCTION;
      display_format_setting      <= DEF_FORMAT;
      sync_time_setting           <= DEF_SYNC_TIME;
      out_enable                  <= '{DEF_OUT_ENABLE, DEF_OUT_ENABLE};
      on_time                     <= '{default: '{default: 17'h0}};
      off_time                    <= '{default: '{default: 17'h0}};
      word                        <= 16'h0;
      digit                       <= 2'h0;
      edit_time                   <= 17'h0;
      edit_sel                    <= 2'h0;
      edit_field                  <= 2'h0;
      pair_sel                    <= 1'b0;
      dirty                       <= 1'b0;
      set_load                    <= 1'b0;
      save_count                  <= 5'h0;
    end else begin
      set_load <= 1'b0;
      if (idle_expired && state != ST_DISPLAY && state != ST_SAVE) begin
        state <= dirty ? ST_SAVE : ST_DISPLAY;
        save_count <= 5'h0;
      end else begin
        case (state)
          ST_DISPLAY: begin
            if (BTN_P && BTN_E) begin
              item  <= MI_FUNCTION;
              dirty <= 1'b0;
              word  <= 16'h0;
              digit <= 2'h0;
              state <= (menu_code == DEF_CODE) ? ST_MENU : ST_CODE;
            end else if (BTN_P && BTN_UP && alarm_access_function) begin
              item  <= MI_OUT1_T;
              edit_sel <= 2'h0;
              pair_sel <= 1'b0;
              dirty <= 1'b0;
              word  <= 16'h0;
              digit <= 2'h0;
              state <= (alarm_access_code == DEF_CODE) ? ST_MENU : ST_CODE;
            end
          end
          ST_CODE: begin
            if (BTN_E) begin
              if (item == MI_OUT1_T) begin
                state <= (word == alarm_access_code) ? ST_MENU : ST_DISPLAY;
              end else begin
                state <= (word == menu_code) ? ST_MENU : ST_DISPLAY;
              end
            end else if (BTN_P) begin
              digit <= digit + 2'h1;
            end else begin
              word <= next_word;
            end
          end
          ST_MENU: begin
            if (BTN_E) begin
              state      <= dirty ? ST_SAVE : ST_DISPLAY;
              save_count <= 5'h0;
            end else if (BTN_UP) begin
              item     <= (item == MI_DEFAULTS) ? MI_FUNCTION : pcc_item_t'(item + 4'h1);
              edit_sel <= 2'h0;
              pair_sel <= 1'b0;
            end else if (BTN_DOWN) begin
              item     <= (item == MI_FUNCTION) ? MI_DEFAULTS : pcc_item_t'(item - 4'h1);
              edit_sel <= 2'h0;
              pair_sel <= 1'b0;
            end else if (BTN_P) begin
              digit      <= 2'h0;
              edit_field <= 2'h0;
              word       <= 16'h0;
              case (item)
                MI_SET_TIME: begin
                  edit_time <= now;
                  state     <= ST_EDIT_TIME;
                end
                MI_SYNC_TIME: begin
                  edit_time <= sync_time_setting;
                  state     <= ST_EDIT_TIME;
                end
                MI_OUT1_T, MI_OUT2_T: begin
                  edit_time <= edit_sel[0] ? off_time[item == MI_OUT2_T][pair_sel] :
                               on_time[item == MI_OUT2_T][pair_sel];
                  state     <= ST_EDIT_TIME;
                end
                MI_ALARM_CODE: begin
                  word  <= alarm_access_code;
                  state <= ST_EDIT_WORD;
                end
                MI_CODE: begin
                  word  <= menu_code;
                  state <= ST_EDIT_WORD;
                end
                MI_FUNCTION, MI_DEFAULTS: begin
                  state <= ST_EDIT_WORD;
                end
                MI_FORMAT:   edit_sel <= display_format_setting;
                MI_OUT1_EN:  edit_sel <= out_enable[0];
                MI_OUT2_EN:  edit_sel <= out_enable[1];
                MI_ALARM_EN: edit_sel <= {1'b0, alarm_access_function};
                default:     edit_sel <= 2'h0;
              endcase
              if (item == MI_FORMAT || item == MI_OUT1_EN || item == MI_OUT2_EN ||
                  item == MI_ALARM_EN) begin
                state <= ST_EDIT_SEL;
              end
            end
          end
          ST_EDIT_SEL: begin
            if (BTN_UP) begin
              edit_sel <= (item == MI_ALARM_EN) ? {1'b0, ~edit_sel[0]} :
                          (item != MI_FORMAT && edit_sel == 2'h2) ? 2'h0 :
                          edit_sel + 2'h1;
            end else if (BTN_DOWN) begin
              edit_sel <= (item == MI_ALARM_EN) ? {1'b0, ~edit_sel[0]} :
                          (item != MI_FORMAT && edit_sel == 2'h0) ? 2'h2 :
                          edit_sel - 2'h1;
            end else if (BTN_E) begin
              dirty <= 1'b1;
              state <= ST_MENU;
              case (item)
                MI_FORMAT:  display_format_setting <= edit_sel;
                MI_OUT1_EN: out_enable[0] <= edit_sel;
                MI_OUT2_EN: out_enable[1] <= edit_sel;
                default:    alarm_access_function <= edit_sel[0];
              endcase
            end
          end
          ST_EDIT_TIME: begin
            if (BTN_UP) begin
              edit_time <= (edit_time + time_step >= DAY_SECONDS) ?
                           edit_time + time_step - DAY_SECONDS : edit_time + time_step;
            end else if (BTN_DOWN) begin
              edit_time <= (edit_time < time_step) ?
                           edit_time + DAY_SECONDS - time_step : edit_time - time_step;
            end else if (BTN_P) begin
              edit_field <= (edit_field == 2'h2) ? 2'h0 : edit_field + 2'h1;
            end else if (BTN_E) begin
              dirty <= 1'b1;
              state <= ST_MENU;
              case (item)
                MI_SET_TIME:  set_load <= 1'b1;
                MI_SYNC_TIME: sync_time_setting <= edit_time;
                default: begin
                  if (edit_sel[0]) begin
                    off_time[item == MI_OUT2_T][pair_sel] <= edit_time;
                  end else begin
                    on_time[item == MI_OUT2_T][pair_sel] <= edit_time;
                  end
                  edit_sel <= edit_sel + 2'h1;
                  pair_sel <= edit_sel[0] ? ~pair_sel : pair_sel;
                end
              endcase
            end
          end
          ST_EDIT_WORD: begin
            if (BTN_P) begin
              digit <= digit + 2'h1;
            end else if (BTN_E) begin
              state <= ST_MENU;
              case (item)
                MI_CODE: begin
                  menu_code <= word;
                  dirty     <= 1'b1;
                end
                MI_ALARM_CODE: begin
                  alarm_access_code <= word;
                  dirty             <= 1'b1;
                end
                MI_FUNCTION: begin
                  if (word == CONFIRM_WORD) begin
                    instrument_function_setting <= 1'b1;
                    dirty <= 1'b1;
                    state <= ST_SAVE;
                    save_count <= 5'h0;
                  end
                end
                default: begin
                  if (word == CONFIRM_WORD) begin
                    menu_code                   <= DEF_CODE;
                    alarm_access_code           <= DEF_CODE;
                    alarm_access_function       <= 1'b0;
                    instrument_function_setting <= DEF_FUNCTION;
                    sync_time_setting           <= DEF_SYNC_TIME;
                    out_enable                  <= '{DEF_OUT_ENABLE, DEF_OUT_ENABLE};
                    dirty                       <= 1'b1;
                  end
                end
              endcase
            end else begin
              word <= next_word;
            end
          end
          ST_SAVE: begin
            save_count <= save_count + 5'h1;
            if (save_count == 5'(SAVE_CYCLES - 1)) begin
              state <= ST_DISPLAY;
              dirty <= 1'b0;
            end
          end
          default: state <= ST_DISPLAY;
        endcase
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DISPLAY_TIME        <= 17'h0;
      DISPLAY_FORMAT      <= DEF_FORMAT;
      DISPLAY_SECONDS     <= 1'b1;
      DISPLAY_FLASH       <= 1'b1;
      MARK_AM             <= 1'b0;
      MARK_PM             <= 1'b0;
      ANN_RESET           <= 1'b0;
      ANN_OUT1            <= 1'b0;
      ANN_OUT2            <= 1'b0;
      CONTROL_OUTPUT_ONE  <= 1'b0;
      CONTROL_OUTPUT_TWO  <= 1'b0;
      IN_MENU             <= 1'b0;
      CODE_PROMPT         <= 1'b0;
      MENU_ITEM           <= 4'h0;
      SAVING              <= 1'b0;
      SAVE_REQ            <= 1'b0;
      INSTRUMENT_FUNCTION <= DEF_FUNCTION;
    end else begin
      DISPLAY_TIME        <= (state == ST_EDIT_TIME) ? edit_time : now;
      DISPLAY_FORMAT      <= display_format_setting;
      DISPLAY_SECONDS     <= (state == ST_EDIT_TIME) ||
                             !display_format_setting[0];
      DISPLAY_FLASH       <= !is_set;
      MARK_AM             <= !display_format_setting[1] && (now < NOON_SECONDS);
      MARK_PM             <= !display_format_setting[1] && (now >= NOON_SECONDS);
      ANN_RESET           <= sync_closed;
      ANN_OUT1            <= out_state[0];
      ANN_OUT2            <= out_state[1];
      CONTROL_OUTPUT_ONE  <= out_state[0];
      CONTROL_OUTPUT_TWO  <= out_state[1];
      IN_MENU             <= (state != ST_DISPLAY) && (state != ST_SAVE);
      CODE_PROMPT         <= (state == ST_CODE);
      MENU_ITEM           <= item;
      SAVING              <= (state == ST_SAVE);
      SAVE_REQ            <= (state == ST_SAVE) && (save_count == 5'h0);
      INSTRUMENT_FUNCTION <= instrument_function_setting;
    end
  end
endmodule

// File: sim/pcc_checker.sv
// Port-level assertions for the panel clock.
// Assumes binding to pcc_top with shortened tick and idle counts.
`timescale 1ns/10ps
module pcc_checker
  import pcc_pkg::*;
#(
  parameter int unsigned TICK_LEN  = 10,
  parameter int unsigned IDLE_LEN  = 50,
  parameter int unsigned PFAIL_LEN = 5
)(
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        SYNC_CONTACT_A,
  input wire logic        SYNC_CONTACT_B,
  input wire logic        BTN_P,
  input wire logic        BTN_E,
  input wire logic        BTN_UP,
  input wire logic        BTN_DOWN,
  input wire logic [16:0] DISPLAY_TIME,
  input wire logic [1:0]  DISPLAY_FORMAT,
  input wire logic        DISPLAY_SECONDS,
  input wire logic        MARK_AM,
  input wire logic        MARK_PM,
  input wire logic        ANN_RESET,
  input wire logic        ANN_OUT1,
  input wire logic        ANN_OUT2,
  input wire logic        CONTROL_OUTPUT_ONE,
  input wire logic        CONTROL_OUTPUT_TWO,
  input wire logic        IN_MENU,
  input wire logic        CODE_PROMPT,
  input wire logic        SAVING,
  input wire logic        SAVE_REQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic        closed;
  logic [31:0] idle_cnt;
  assign closed = SYNC_CONTACT_A && SYNC_CONTACT_B;
  // Cycles in menu without a press
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) idle_cnt <= 32'h0;
    else if (!IN_MENU || BTN_P || BTN_E || BTN_UP || BTN_DOWN) idle_cnt <= 32'h0;
    else idle_cnt <= idle_cnt + 32'h1;
  end
  sequence s_settled;
    $past(RST_N) && !IN_MENU && !$past(IN_MENU) && !$past(IN_MENU, 2);
  endsequence
  sequence s_synced;
    (closed && !IN_MENU) [*4];
  endsequence
  sequence s_save_run;
    SAVING [*8];
  endsequence
  property p_ann_reset; 1'b1 |=> ANN_RESET == $past(closed); endproperty
  a_ann_reset: assert property (p_ann_reset) else $error("reset lamp mismatch");
  property p_sync_hold; s_synced |-> ANN_RESET && $stable(DISPLAY_TIME); endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("time moved in sync");
  property p_seconds; s_settled |-> DISPLAY_SECONDS == !DISPLAY_FORMAT[0]; endproperty
  a_seconds: assert property (p_seconds) else $error("seconds flag wrong");
  property p_marks;
    s_settled |-> (DISPLAY_FORMAT[1] ? (!MARK_AM && !MARK_PM) :
      (MARK_PM == (DISPLAY_TIME >= NOON_SECONDS) && MARK_AM == !MARK_PM));
  endproperty
  a_marks: assert property (p_marks) else $error("day half marker wrong");
  property p_menu_entry;
    BTN_P && BTN_E && !IN_MENU && !CODE_PROMPT && !SAVING |-> ##2 (IN_MENU || CODE_PROMPT);
  endproperty
  a_menu_entry: assert property (p_menu_entry) else $error("menu not entered");
  property p_idle; idle_cnt <= IDLE_LEN + 20; endproperty
  a_idle: assert property (p_idle) else $error("menu idle too long");
  property p_save; SAVE_REQ |-> ##[0:1] s_save_run; endproperty
  a_save: assert property (p_save) else $error("saving too short");
  property p_count;
    s_settled ##0 (!ANN_RESET && !$past(ANN_RESET) && DISPLAY_TIME != $past(DISPLAY_TIME))
      |-> DISPLAY_TIME == $past(DISPLAY_TIME) + 17'h1 || DISPLAY_TIME == 17'h0;
  endproperty
  a_count: assert property (p_count) else $error("time step wrong");
  property p_ann_out;
    ANN_OUT1 == CONTROL_OUTPUT_ONE && ANN_OUT2 == CONTROL_OUTPUT_TWO;
  endproperty
  a_ann_out: assert property (p_ann_out) else $error("output lamp mismatch");
endmodule

// File: sim/pcc_panel_model.sv
// Front panel buttons and synchronising contact pair.
// Assumes the clock is shared with the block; drives on rising edges.
`timescale 1ns/10ps
module pcc_panel_model (
  input  wire logic clk,
  output logic      btn_p,
  output logic      btn_e,
  output logic      btn_up,
  output logic      btn_down,
  output logic      contact_a,
  output logic      contact_b
);
  initial begin
    {btn_p, btn_e, btn_up, btn_down} = 4'h0;
    contact_a = 1'b1;
    contact_b = 1'b0;
  end
  // One-cycle press of keys {P, E, UP, DOWN}
  task automatic press(input logic [3:0] keys);
    @(posedge clk);
    {btn_p, btn_e, btn_up, btn_down} <= keys;
    @(posedge clk);
    {btn_p, btn_e, btn_up, btn_down} <= 4'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  // Open contact leaves the second terminal low
  task automatic contacts(input logic shut);
    @(posedge clk);
    contact_b <= shut;
  endtask
endmodule

// File: sim/test_panel_clock_config_sync.sv
// Self-checking bench for the panel clock.
// Assumes shortened counts: tick 10, idle 50, supply loss 5 cycles.
`timescale 1ns/10ps
module test_panel_clock_config_sync
  import pcc_pkg::*;
;
  localparam int unsigned TICK = 10;
  localparam int unsigned IDLE = 50;
  localparam int unsigned PFAIL = 5;
  localparam logic [3:0] K_P = 4'h8, K_E = 4'h4, K_UP = 4'h2, K_PE = 4'hc, K_DN = 4'h1;
  logic clk, rst_n, power_low, btn_p, btn_e, btn_up, btn_down, con_a, con_b;
  logic [16:0] disp_time;
  logic [1:0]  disp_fmt;
  logic [3:0]  item;
  logic secs, flash, am, pm, ann_rst, ann1, ann2, out1, out2, in_menu, prompt, saving, save_req;
  logic func, save_seen;
  int n_fail = 0;
  int check_count = 0;
  pcc_top #(.TICK_LEN(TICK), .IDLE_LEN(IDLE), .PFAIL_LEN(PFAIL)) dut_u (
    .CLK(clk), .RST_N(rst_n), .SYNC_CONTACT_A(con_a), .SYNC_CONTACT_B(con_b),
    .POWER_LOW(power_low), .BTN_P(btn_p), .BTN_E(btn_e), .BTN_UP(btn_up),
    .BTN_DOWN(btn_down), .DISPLAY_TIME(disp_time), .DISPLAY_FORMAT(disp_fmt),
    .DISPLAY_SECONDS(secs), .DISPLAY_FLASH(flash), .MARK_AM(am), .MARK_PM(pm),
    .ANN_RESET(ann_rst), .ANN_OUT1(ann1), .ANN_OUT2(ann2), .CONTROL_OUTPUT_ONE(out1),
    .CONTROL_OUTPUT_TWO(out2), .IN_MENU(in_menu), .CODE_PROMPT(prompt),
    .MENU_ITEM(item), .SAVING(saving), .SAVE_REQ(save_req), .INSTRUMENT_FUNCTION(func));
  pcc_panel_model panel_u (.clk(clk), .btn_p(btn_p), .btn_e(btn_e), .btn_up(btn_up),
    .btn_down(btn_down), .contact_a(con_a), .contact_b(con_b));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) if (save_req === 1'b1) save_seen <= 1'b1;
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic keys(input logic [3:0] k, input int n);
    repeat (n) panel_u.press(k);
  endtask
  // Leave the menu and wait for storage to finish
  task automatic leave_menu;
    save_seen = 1'b0;
    panel_u.press(K_E);
    for (int i = 0; i < 100 && (saving !== 1'b0 || in_menu !== 1'b0); i++) settle(0);
    check(save_seen, 1'b1);
    check({saving, in_menu}, 2'b00);
  endtask
  task automatic test_reset;
    settle(3 * TICK);
    check(func, 1'b1);
    check(disp_fmt, DEF_FORMAT);
    check({flash, disp_time}, {1'b1, 17'h0});
    check(am, 1'b1);
    check({ann1, ann2, out1, out2}, 4'h0);
  endtask
  task automatic test_menu_idle;
    panel_u.press(K_PE);
    check({in_menu, prompt, item}, {2'b10, 4'(MI_FUNCTION)});
    settle(IDLE + 30);
    check(in_menu, 1'b0);
  endtask
  task automatic test_set_time;
    panel_u.press(K_PE);
    panel_u.press(K_UP);
    panel_u.press(K_UP);
    check(item, 4'(MI_SET_TIME));
    panel_u.press(K_P);
    panel_u.press(K_UP);
    check({secs, disp_time}, {1'b1, HOUR_SECONDS});
    panel_u.press(K_P);
    panel_u.press(K_UP);
    panel_u.press(K_P);
    panel_u.press(K_UP);
    check(disp_time, HOUR_SECONDS + MINUTE_SECONDS + 17'h1);
    panel_u.press(K_E);
    check(flash, 1'b0);
    leave_menu();
    check(disp_time > 17'd3661 && disp_time < 17'd3668, 1'b1);
  endtask
  task automatic test_sync;
    panel_u.contacts(1'b1);
    settle(3 * TICK);
    check({ann_rst, disp_time}, {1'b1, DEF_SYNC_TIME});
    panel_u.contacts(1'b0);
    settle(2 * TICK + 5);
    check(ann_rst, 1'b0);
    check(disp_time >= DEF_SYNC_TIME + 17'd2 && disp_time <= DEF_SYNC_TIME + 17'd3, 1'b1);
  endtask
  task automatic test_formats;
    for (int k = 1; k < 4; k++) begin
      panel_u.press(K_PE);
      panel_u.press(K_UP);
      panel_u.press(K_P);
      panel_u.press(K_UP);
      panel_u.press(K_E);
      leave_menu();
      check({disp_fmt, secs}, {2'(k), ~k[0]});
      check({am, pm}, {1'b0, k < 2});
    end
  endtask
  task automatic test_power;
    @(posedge clk);
    power_low <= 1'b1;
    settle(PFAIL + 3);
    @(posedge clk);
    power_low <= 1'b0;
    settle(3 * TICK);
    check({flash, disp_time}, {1'b1, 17'h0});
    check(disp_fmt, 2'h3);
  endtask
  // Output one on at one second, then start the clock from zero
  task automatic test_output;
    panel_u.press(K_PE);
    keys(K_UP, 4);
    panel_u.press(K_P);
    panel_u.press(K_UP);
    panel_u.press(K_E);
    check(item, 4'(MI_OUT1_EN));
    keys(K_UP, 1);
    keys(K_P, 3);
    panel_u.press(K_UP);
    panel_u.press(K_E);
    keys(K_DN, 3);
    check(item, 4'(MI_SET_TIME));
    panel_u.press(K_P);
    panel_u.press(K_E);
    check({out1, ann1}, 2'b00);
    leave_menu();
    check({out1, ann1, flash}, 3'b110);
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #60us;
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    power_low = 1'b0;
    save_seen = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    test_reset();
    test_menu_idle();
    test_set_time();
    test_sync();
    test_formats();
    test_power();
    test_output();
    test_done();
  end
endmodule
bind pcc_top pcc_checker #(.TICK_LEN(TICK_LEN), .IDLE_LEN(IDLE_LEN), .PFAIL_LEN(PFAIL_LEN))
  chk_u (.*);
